// ### hdl/ecr_cfg_mem.sv
// Configuration word store with two registered read ports
`timescale 1ns/1ps
`default_nettype none
module ecr_cfg_mem
  import ecr_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = CFG_WORDS,
  parameter int AW = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr_a,
  output logic [WIDTH-1:0] rd_data_a,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [WIDTH-1:0] rd_data_b
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= WIDTH'(CFG_WORD_RST);
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      rd_data_a <= mem_q[rd_addr_a];
      rd_data_b <= mem_q[rd_addr_b];
    end
  end
endmodule : ecr_cfg_mem
`default_nettype wire

// ### hdl/ecr_checksum_engine.sv
// Bit-serial checksum over the configuration words in ascending order
`timescale 1ns/1ps
`default_nettype none
module ecr_checksum_engine
  import ecr_pkg::*;
#(
  parameter int WORDS = CFG_WORDS,
  parameter int AW = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  output logic [AW-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  output logic [15:0] crc,
  output logic done
);
  typedef enum logic [1:0] {CK_IDLE, CK_FETCH, CK_LOAD, CK_SHIFT} ecr_ck_state_t;

  ecr_ck_state_t state_q;
  logic [DATA_W-1:0] sh_q;
  logic [4:0] bit_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= CK_IDLE;
      rd_addr <= '0;
      sh_q <= '0;
      bit_q <= '0;
      crc <= CHECKSUM_RST;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        CK_IDLE: begin
          if (start) begin
            crc <= CHECKSUM_RST; // RULE20
            rd_addr <= '0;
            state_q <= CK_FETCH;
          end
        end
        CK_FETCH: begin
          state_q <= CK_LOAD;
        end
        CK_LOAD: begin
          sh_q <= rd_data;
          bit_q <= 5'(DATA_W - 1);
          state_q <= CK_SHIFT;
        end
        CK_SHIFT: begin
          crc <= crc_step(crc, sh_q[DATA_W-1]); // RULE20
          sh_q <= {sh_q[DATA_W-2:0], 1'b0};
          bit_q <= bit_q - 5'd1;
          if (bit_q == 5'd0) begin
            if (rd_addr == AW'(WORDS - 1)) begin
              done <= 1'b1;
              state_q <= CK_IDLE;
            end else begin
              rd_addr <= rd_addr + 1'b1;
              state_q <= CK_FETCH;
            end
          end
        end
        default: begin
          state_q <= CK_IDLE;
        end
      endcase
    end
  end
endmodule : ecr_checksum_engine
`default_nettype wire

// ### hdl/ecr_event_status.sv
// Event status with read-to-clear, checksum readback and the serial front end
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Supply low start and end set bit 7
// RULE2: Supply high start and end set bit 6
// RULE3: Thermal warning start and end set bit 5
// RULE4: Thermal shutdown start and end set bit 4
// RULE5: Any switch threshold crossing sets bit 3
// RULE6: First finished poll cycle also sets bit 3
// RULE7: Even-parity frame discarded, sets bit 2
// RULE8: Response parity flag copies bit 2
// RULE9: Only exact 32-bit frames accepted, else bit 1
// RULE10: No clock edges means no length error
// RULE11: Response frame flag copies bit 1
// RULE12: Every reset leaves bit 0 set
// RULE13: Reset restores all registers and state; soft reset leaves the meta_q, sync_q and prev_q stages as they are
// RULE14: Response reset flag copies bit 0
// RULE15: Reading status clears its reported bits
// RULE16: Checksum in low 16 bits, reset ones
// RULE17: Host compares its own checksum
// RULE18: Interrupt released at end of status read
// RULE19: Finished checksum sets bit 8
// RULE20: CCITT over config words, ascending, ones start
// RULE21: Interrupt low while any status bit set
module ecr_event_status
  import ecr_pkg::*;
#(
  parameter int CFG_N = CFG_WORDS,
  parameter int SW_N = SWITCH_COUNT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic int_n,
  input wire logic supply_low_event,
  input wire logic supply_high_event,
  input wire logic thermal_warning_event,
  input wire logic thermal_shutdown_event,
  input wire logic [SW_N-1:0] switch_input,
  input wire logic poll_active,
  input wire logic poll_cycle_done
);
  localparam int SYNC_W = SW_N + 7;
  localparam int CA_W = $clog2(CFG_N);
  localparam logic [SYNC_W-1:0] SYNC_RST = {{(SYNC_W - 1){1'b0}}, 1'b1};

  logic rst_all;
  logic sys_rst_n;
  logic soft_rst_q;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] prev_q;
  logic [2:0] prime_q;
  logic in_frame;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [5:0] bit_cnt_q;
  logic [31:0] rx_q;
  logic [31:0] tx_q;
  logic head_q;
  logic load_q;
  logic [23:0] snap_q;
  logic [23:0] status_q;
  logic [23:0] status_d;
  logic [23:0] ev_set;
  logic [23:0] ev_clr;
  logic len_err;
  logic par_err;
  logic frame_ok;
  logic wr_cmd;
  logic [5:0] fr_addr;
  logic [23:0] fr_data;
  logic [5:0] head_addr;
  logic [23:0] rd_mux;
  logic poll_prev_q;
  logic poll_pend_q;
  logic poll_ev;
  logic crc_start_q;
  logic crc_done;
  logic [15:0] crc_val;
  logic [23:0] cfg_rd_spi;
  logic [23:0] cfg_rd_crc;
  logic [CA_W-1:0] crc_addr;
  logic cfg_we;
  logic ctrl_wr;

  function automatic logic is_cfg(input logic [5:0] a);
    is_cfg = (a >= OFS_CFG_BASE) && (a < OFS_CFG_BASE + 6'(CFG_N));
  endfunction : is_cfg

  function automatic logic [CA_W-1:0] cfg_idx(input logic [5:0] a);
    cfg_idx = CA_W'(a - OFS_CFG_BASE);
  endfunction : cfg_idx

  // Hardware reset or the one-cycle software reset pulse
  assign rst_all = !rst_n || soft_rst_q; // RULE13
  assign sys_rst_n = !rst_all;

  // Pins and analogue levels: two stages, then an edge-history stage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
      prev_q <= SYNC_RST;
    end else begin
      meta_q <= {switch_input, supply_low_event, supply_high_event, thermal_warning_event,
                 thermal_shutdown_event, spi_mosi, spi_sclk, spi_cs_n};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Level edges count only once the history holds real samples
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      prime_q <= '0;
    end else begin
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  assign in_frame = !sync_q[0];
  assign cs_fall = prev_q[0] && !sync_q[0];
  assign cs_rise = !prev_q[0] && sync_q[0];
  assign sclk_rise = in_frame && !prev_q[1] && sync_q[1];
  assign sclk_fall = in_frame && prev_q[1] && !sync_q[1];

  // Bit counter saturates so that long frames stay wrong
  always_ff @(posedge clk_sys) begin
    if (rst_all || cs_fall) begin
      bit_cnt_q <= '0;
      rx_q <= '0;
    end else if (sclk_rise) begin
      rx_q <= {rx_q[30:0], sync_q[2]};
      if (bit_cnt_q != CNT_SAT) begin
        bit_cnt_q <= bit_cnt_q + 6'd1; // RULE9
      end
    end
  end

  // After command and address bits, fetch the word to send back
  always_ff @(posedge clk_sys) begin
    if (rst_all || cs_fall) begin
      head_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (!head_q && bit_cnt_q == HEAD_BITS) begin
        head_q <= 1'b1;
        load_q <= 1'b1;
      end
    end
  end

  assign head_addr = rx_q[5:0];

  always_comb begin
    rd_mux = '0;
    if (head_addr == OFS_EVENT_STATUS) begin
      rd_mux = status_q;
    end else if (head_addr == OFS_CHECKSUM) begin
      rd_mux = {8'h00, crc_val}; // RULE16
    end else if (is_cfg(head_addr)) begin
      rd_mux = cfg_rd_spi;
    end
  end

  // Response word: flags at frame start, data and odd parity once addressed
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      tx_q <= '0;
      snap_q <= '0;
    end else if (cs_fall) begin
      tx_q <= {status_q[BIT_POR], status_q[BIT_FRAME], status_q[BIT_PARITY], 29'h0}; // RULE8
      snap_q <= '0;
    end else if (load_q) begin
      tx_q <= {tx_q[31:29], 4'h0, rd_mux, ~^{tx_q[31:29], rd_mux}};
      snap_q <= (head_addr == OFS_EVENT_STATUS) ? status_q : '0;
    end
  end

  // Reset and frame flags reach the wire as the first response bits
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= in_frame;
      if (cs_fall) begin
        spi_miso <= status_q[BIT_POR]; // RULE14
      end else if (sclk_fall) begin
        spi_miso <= bit_cnt_q[5] ? 1'b0 : tx_q[~bit_cnt_q[4:0]]; // RULE11
      end
    end
  end

  // Frame checks at chip select release
  assign len_err = cs_rise && bit_cnt_q != 6'h00 && bit_cnt_q != FRAME_BITS_C; // RULE9 RULE10
  assign par_err = cs_rise && bit_cnt_q == FRAME_BITS_C && !(^rx_q); // RULE7
  assign frame_ok = cs_rise && bit_cnt_q == FRAME_BITS_C && (^rx_q);
  assign wr_cmd = rx_q[FR_WRITE];
  assign fr_addr = rx_q[FR_ADDR_HI:FR_ADDR_LO];
  assign fr_data = rx_q[FR_DATA_HI:FR_DATA_LO];
  assign cfg_we = frame_ok && wr_cmd && is_cfg(fr_addr);
  assign ctrl_wr = frame_ok && wr_cmd && fr_addr == OFS_CONTROL;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= ctrl_wr && fr_data[CTRL_SOFT_RST]; // RULE12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      crc_start_q <= 1'b0;
    end else begin
      crc_start_q <= ctrl_wr && fr_data[CTRL_TRIG]; // RULE20
    end
  end

  // Polling start arms a one-shot for the first finished cycle
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      poll_prev_q <= 1'b0;
      poll_pend_q <= 1'b0;
    end else begin
      poll_prev_q <= poll_active;
      if (poll_active && !poll_prev_q) begin
        poll_pend_q <= 1'b1;
      end else if (poll_cycle_done) begin
        poll_pend_q <= 1'b0;
      end
    end
  end

  assign poll_ev = poll_pend_q && poll_cycle_done;

  // Only bits reported by the read are cleared; new events win
  always_comb begin
    ev_set = '0;
    for (int i = 0; i < 4; i++) begin
      ev_set[BIT_TSD + i] = prime_q[2] && (sync_q[3 + i] != prev_q[3 + i]); // RULE1 RULE2 RULE3 RULE4
    end
    ev_set[BIT_SWITCH] = (prime_q[2] && sync_q[SYNC_W-1:7] != prev_q[SYNC_W-1:7]) // RULE5
                         || poll_ev; // RULE6
    ev_set[BIT_PARITY] = par_err; // RULE7
    ev_set[BIT_FRAME] = len_err; // RULE9
    ev_set[BIT_CHECKSUM] = crc_done; // RULE19
    ev_clr = (frame_ok && !wr_cmd && fr_addr == OFS_EVENT_STATUS) ? snap_q : '0; // RULE15
    status_d = (status_q & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      status_q <= EVENT_STATUS_RST; // RULE12
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      int_n <= 1'b0;
    end else begin
      int_n <= ~|status_d; // RULE18 RULE21
    end
  end

  ecr_cfg_mem #(
    .WIDTH(DATA_W),
    .DEPTH(CFG_N),
    .AW(CA_W)
  ) u_cfg_mem (
    .clk_sys(clk_sys),
    .rst_n(sys_rst_n),
    .wr_en(cfg_we),
    .wr_addr(cfg_idx(fr_addr)),
    .wr_data(fr_data),
    .rd_addr_a(cfg_idx(head_addr)),
    .rd_data_a(cfg_rd_spi),
    .rd_addr_b(crc_addr),
    .rd_data_b(cfg_rd_crc)
  );

  ecr_checksum_engine #(
    .WORDS(CFG_N),
    .AW(CA_W)
  ) u_checksum (
    .clk_sys(clk_sys),
    .rst_n(sys_rst_n),
    .start(crc_start_q),
    .rd_addr(crc_addr),
    .rd_data(cfg_rd_crc),
    .crc(crc_val),
    .done(crc_done)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_supply_low;
    (prime_q[2] && !soft_rst_q && sync_q[6] != prev_q[6]) |=> status_q[BIT_UV];
  endproperty
  a_supply_low: assert property (p_supply_low) // RULE1
    else $error("supply low edge not flagged");

  property p_supply_high;
    (prime_q[2] && !soft_rst_q && sync_q[5] != prev_q[5]) |=> status_q[BIT_OV];
  endproperty
  a_supply_high: assert property (p_supply_high) // RULE2
    else $error("supply high edge not flagged");

  property p_thermal_warn;
    (prime_q[2] && !soft_rst_q && $changed(sync_q[4])) |=> status_q[BIT_TW];
  endproperty
  a_thermal_warn: assert property (p_thermal_warn) // RULE3
    else $error("thermal warning edge not flagged");

  property p_switch_change;
    (!soft_rst_q && (poll_ev || (prime_q[2] && sync_q[SYNC_W-1:7] != prev_q[SYNC_W-1:7])))
      |=> status_q[BIT_SWITCH];
  endproperty
  a_switch_change: assert property (p_switch_change) // RULE5
    else $error("switch change not flagged");

  property p_parity_fail;
    (par_err && !soft_rst_q) |=> status_q[BIT_PARITY] && !$past(cfg_we);
  endproperty
  a_parity_fail: assert property (p_parity_fail) // RULE7
    else $error("parity error not flagged or frame used");

  property p_parity_flag;
    (cs_fall && !soft_rst_q) |=> tx_q[RSP_PARITY] == $past(status_q[BIT_PARITY]);
  endproperty
  a_parity_flag: assert property (p_parity_flag) // RULE8
    else $error("parity response flag wrong");

  property p_len_err;
    (len_err && !soft_rst_q) |=> status_q[BIT_FRAME] ##1 !spi_miso_oe [*1];
  endproperty
  a_len_err: assert property (p_len_err) // RULE9
    else $error("frame length error not flagged");

  property p_no_clock;
    (cs_rise && bit_cnt_q == 6'h00 && !status_q[BIT_FRAME] && !soft_rst_q)
      |=> !status_q[BIT_FRAME];
  endproperty
  a_no_clock: assert property (p_no_clock) // RULE10
    else $error("length error on clockless frame");

  property p_frame_flag;
    (cs_fall && !soft_rst_q) |=> tx_q[RSP_FRAME] == $past(status_q[BIT_FRAME]);
  endproperty
  a_frame_flag: assert property (p_frame_flag) // RULE11
    else $error("frame response flag wrong");

  property p_soft_reset;
    soft_rst_q |=> status_q == EVENT_STATUS_RST && !int_n && bit_cnt_q == 6'h00;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // RULE12
    else $error("reset did not restore status");

  property p_read_clear;
    (frame_ok && !wr_cmd && fr_addr == OFS_EVENT_STATUS && snap_q[BIT_UV]
      && !ev_set[BIT_UV] && !soft_rst_q) |=> !status_q[BIT_UV];
  endproperty
  a_read_clear: assert property (p_read_clear) // RULE15
    else $error("status read did not clear");

  property p_int_release;
    $rose(int_n) |-> $past(frame_ok && !wr_cmd && fr_addr == OFS_EVENT_STATUS);
  endproperty
  a_int_release: assert property (p_int_release) // RULE18
    else $error("interrupt released without status read");

  property p_int_level;
    (|status_q) |-> !int_n;
  endproperty
  a_int_level: assert property (p_int_level) // RULE21
    else $error("interrupt high while status set");

  property p_checksum_done;
    (crc_done && !soft_rst_q) |=> status_q[BIT_CHECKSUM];
  endproperty
  a_checksum_done: assert property (p_checksum_done) // RULE19
    else $error("checksum completion not flagged");
endmodule : ecr_event_status
`default_nettype wire

// ### include/ecr_pkg.sv
// Shared constants, field positions and the checksum step for the event status block
package ecr_pkg;
  localparam int DATA_W = 24;
  localparam int SWITCH_COUNT = 24;
  localparam int CFG_WORDS = 8;
  localparam logic [5:0] FRAME_BITS_C = 6'h20;
  localparam logic [5:0] HEAD_BITS = 6'h07;
  localparam logic [5:0] CNT_SAT = 6'h3F;
  localparam logic [5:0] OFS_EVENT_STATUS = 6'h02;
  localparam logic [5:0] OFS_CHECKSUM = 6'h03;
  localparam logic [5:0] OFS_CFG_BASE = 6'h10;
  localparam logic [5:0] OFS_CONTROL = 6'h1E;
  localparam logic [23:0] EVENT_STATUS_RST = 24'h00_0001;
  localparam logic [23:0] CFG_WORD_RST = 24'h00_0000;
  localparam logic [15:0] CHECKSUM_RST = 16'hFFFF;
  localparam logic [15:0] CCITT_POLY = 16'h1021;
  localparam int BIT_POR = 0;
  localparam int BIT_FRAME = 1;
  localparam int BIT_PARITY = 2;
  localparam int BIT_SWITCH = 3;
  localparam int BIT_TSD = 4;
  localparam int BIT_TW = 5;
  localparam int BIT_OV = 6;
  localparam int BIT_UV = 7;
  localparam int BIT_CHECKSUM = 8;
  localparam int CTRL_TRIG = 0;
  localparam int CTRL_SOFT_RST = 1;
  localparam int FR_WRITE = 31;
  localparam int FR_ADDR_HI = 30;
  localparam int FR_ADDR_LO = 25;
  localparam int FR_DATA_HI = 24;
  localparam int FR_DATA_LO = 1;
  localparam int RSP_POR = 31;
  localparam int RSP_FRAME = 30;
  localparam int RSP_PARITY = 29;

  // One bit of the CCITT checksum, message bit entering at the top
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din);
    crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ din) ? CCITT_POLY : 16'h0000);
  endfunction : crc_step
endpackage : ecr_pkg

// ### testbench/ecr_event_status_tb.sv
// Self-checking bench for the event status and checksum readback block
`timescale 1ns/1ps
`default_nettype none
module ecr_event_status_tb;
  import ecr_pkg::*;
  logic clk_sys, rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, int_n;
  logic [3:0] lvl;
  logic [SWITCH_COUNT-1:0] sw;
  logic poll_active, poll_cycle_done;
  logic [31:0] rsp;
  logic [23:0] rdata;
  int n_mismatch, total_checks;

  ecr_event_status dut (.clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .int_n(int_n), .supply_low_event(lvl[0]),
    .supply_high_event(lvl[1]), .thermal_warning_event(lvl[2]),
    .thermal_shutdown_event(lvl[3]), .switch_input(sw), .poll_active(poll_active),
    .poll_cycle_done(poll_cycle_done));
  ecr_host_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %b expected %b", $time, m, got, exp);
    end
  endtask : chk_bit

  // Command word with odd parity in bit 0
  function automatic logic [31:0] frame(input logic wr, input logic [5:0] a,
      input logic [23:0] d);
    logic [30:0] h;
    h = {wr, a, d};
    return {h, ~^h};
  endfunction : frame

  task automatic rd(input logic [5:0] a);
    host.xfer(32, frame(1'b0, a, 24'h00_0000), rsp);
    rdata = rsp[24:1];
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    host.xfer(32, frame(1'b1, a, d), rsp);
  endtask : wr

  task automatic st(input logic [23:0] exp, input string m);
    rd(OFS_EVENT_STATUS);
    chk_word(rdata, exp, m);
  endtask : st

  task automatic t_reset();
    chk_bit(int_n, 1'b0, "int after reset");
    chk_bit(spi_miso_oe, 1'b0, "data out idle after reset");
    // Output enable must stand high in mid-frame
    fork
      rd(OFS_EVENT_STATUS);
      begin
        repeat (12) @(posedge clk_sys);
        chk_bit(spi_miso_oe, 1'b1, "data out driven in frame");
      end
    join
    chk_bit(rsp[31], 1'b1, "reset flag");
    chk_word(rdata, 24'h00_0001, "status after reset");
    chk_bit(int_n, 1'b1, "int after status read");
    chk_bit(spi_miso_oe, 1'b0, "data out released after frame");
    st(24'h00_0000, "status cleared");
    rd(OFS_CHECKSUM);
    chk_word(rdata, 24'h00_FFFF, "checksum reset");
  endtask : t_reset

  // Both edges of each condition report on its own bit
  task automatic t_levels();
    for (int k = 0; k < 4; k++) begin
      for (int ph = 0; ph < 2; ph++) begin
        @(posedge clk_sys);
        lvl[k] <= ~lvl[k];
        repeat (8) @(posedge clk_sys);
        chk_bit(int_n, 1'b0, "int on condition edge");
        st(24'h00_0001 << (BIT_UV - k), "condition edge");
      end
    end
  endtask : t_levels

  task automatic t_switch();
    @(posedge clk_sys);
    sw[0] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    st(24'h00_0008, "first switch");
    sw[SWITCH_COUNT-1] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    st(24'h00_0008, "last switch");
    poll_active <= 1'b1;
    repeat (4) @(posedge clk_sys);
    poll_cycle_done <= 1'b1;
    @(posedge clk_sys);
    poll_cycle_done <= 1'b0;
    repeat (6) @(posedge clk_sys);
    st(24'h00_0008, "first poll done");
  endtask : t_switch

  // Bad parity and wrong lengths are refused and flagged
  task automatic t_link();
    host.xfer(32, frame(1'b1, OFS_CFG_BASE, 24'h00_0055) ^ 32'h0000_0001, rsp);
    rd(OFS_EVENT_STATUS);
    chk_bit(rsp[29], 1'b1, "parity flag");
    chk_word(rdata, 24'h00_0004, "parity bit");
    rd(OFS_CFG_BASE);
    chk_word(rdata, 24'h00_0000, "parity frame discarded");
    host.xfer(31, frame(1'b1, OFS_CFG_BASE, 24'h00_0055), rsp);
    rd(OFS_EVENT_STATUS);
    chk_bit(rsp[30], 1'b1, "frame flag");
    chk_word(rdata, 24'h00_0002, "short frame");
    host.xfer(33, frame(1'b1, OFS_CFG_BASE, 24'h00_0055), rsp);
    st(24'h00_0002, "long frame");
    rd(OFS_CFG_BASE);
    chk_word(rdata, 24'h00_0000, "bad length discarded");
    host.xfer(0, frame(1'b1, OFS_CFG_BASE, 24'h00_0055), rsp);
    st(24'h00_0000, "no clock frame");
  endtask : t_link

  task automatic t_crc();
    logic [23:0] cfg [CFG_WORDS];
    logic [15:0] c;
    int n;
    foreach (cfg[i]) cfg[i] = 24'h00_0000;
    cfg[0] = 24'h12_3456;
    cfg[CFG_WORDS-1] = 24'hAB_CDEF;
    wr(OFS_CFG_BASE, cfg[0]);
    wr(OFS_CFG_BASE + 6'h07, cfg[CFG_WORDS-1]);
    c = 16'hFFFF;
    foreach (cfg[w]) begin
      for (int b = 23; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ cfg[w][b]) ? CCITT_POLY : 16'h0000);
      end
    end
    wr(OFS_CONTROL, 24'h00_0001);
    n = 0;
    while (int_n !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 2000) begin
      n_mismatch++;
      $display("wrong value at %0t: checksum never finished", $time);
      results();
    end
    st(24'h00_0100, "checksum done");
    rd(OFS_CHECKSUM);
    chk_word(rdata, {8'h00, c}, "checksum value");
  endtask : t_crc

  task automatic t_resets();
    wr(OFS_CONTROL, 24'h00_0002);
    chk_bit(int_n, 1'b0, "int after soft reset");
    rd(OFS_EVENT_STATUS);
    chk_bit(rsp[31], 1'b1, "reset flag soft");
    chk_word(rdata, 24'h00_0001, "status soft reset");
    rd(OFS_CFG_BASE);
    chk_word(rdata, 24'h00_0000, "config after reset");
    rd(OFS_CHECKSUM);
    chk_word(rdata, 24'h00_FFFF, "checksum after reset");
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    st(24'h00_0001, "status hard reset");
  endtask : t_resets

  initial begin
    rst_n = 1'b0;
    lvl = 4'h0;
    sw = '0;
    poll_active = 1'b0;
    poll_cycle_done = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_reset();
    t_levels();
    t_switch();
    t_link();
    t_crc();
    t_resets();
    results();
  end
endmodule : ecr_event_status_tb
`default_nettype wire

// ### testbench/ecr_host_model.sv
// Host controller model: mode 0 serial frames of any bit count
`timescale 1ns/1ps
`default_nettype none
module ecr_host_model (
  input wire logic clk_sys,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // Clock idles low between frames; data idles at the inverse of its last level
  task automatic xfer(input int nbits, input logic [31:0] w, output logic [31:0] rsp);
    rsp = 32'h0000_0000;
    @(posedge clk_sys);
    spi_cs_n <= 1'b0;
    spi_mosi <= w[31];
    repeat (8) @(posedge clk_sys);
    // Normal frames carry 32 bits; other counts only when a scenario asks
    for (int i = 0; i < nbits; i++) begin
      rsp = {rsp[30:0], spi_miso};
      spi_sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      spi_sclk <= 1'b0;
      spi_mosi <= (i < 31) ? w[30-i] : ~spi_mosi;
      repeat (5) @(posedge clk_sys);
    end
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    repeat (12) @(posedge clk_sys);
  endtask : xfer
endmodule : ecr_host_model
`default_nettype wire
